// file: pdoc_pkg.sv
// How it works
// RULE1 - Open-drain capable pins go open drain when their select bit is one
// RULE2 - Slew capable pins go fast slew when their select bit is one
// RULE3 - All drive-select registers reset to zero: push-pull, normal slew
// RULE4 - First port: bits 0-3 fast slew, bits 4-7 open drain
// RULE5 - Second port: bits 0-3 fast slew, bits 4-7 open drain
// RULE6 - Third port: bits 2,3,4,7 open drain; test-port bits do nothing
// RULE7 - Fourth port: only bits 1 and 2 exist, fast slew
// RULE8 - Enable-out view reads one when driving, zero when high impedance; open-drain pins released high still read one here
// RULE9 - Enable comes from logic array, direction register or repeater; here address-select bits also enable ports A and B
// RULE10 - Enable-out views show final enable; absent positions read zero
// RULE11 - First port: cpu io, array out/in, latched address, repeater
// RULE12 - Second port: cpu io, address, array in, allocator-picked out
// RULE13 - Third port: cpu io and array out/in on pins 2,3,4,7 only
// RULE14 - Two programming status pins are enabled together as a pair
// RULE15 - Six-pin programming takes third-port pins 3 and 4 exclusively
// RULE16 - Third-port pin 3 may signal flash program or erase done
// RULE17 - Boundary-scan pins never act as general io
// RULE18 - Writes to enable-out views are ignored
package pdoc_pkg;
  localparam logic [7:0] OFF_A_DRV = 8'h08;
  localparam logic [7:0] OFF_B_DRV = 8'h09;
  localparam logic [7:0] OFF_A_OEV = 8'h0c;
  localparam logic [7:0] OFF_B_OEV = 8'h0d;
  localparam logic [7:0] OFF_C_DRV = 8'h16;
  localparam logic [7:0] OFF_D_DRV = 8'h17;
  localparam logic [7:0] OFF_C_OEV = 8'h1a;
  localparam logic [7:0] OFF_D_OEV = 8'h1b;
  // Own registers for the pin mode controls
  localparam logic [7:0] OFF_A_DIR = 8'h20;
  localparam logic [7:0] OFF_B_DIR = 8'h21;
  localparam logic [7:0] OFF_C_DIR = 8'h22;
  localparam logic [7:0] OFF_D_DIR = 8'h23;
  localparam logic [7:0] OFF_A_ADR = 8'h24;
  localparam logic [7:0] OFF_B_ADR = 8'h25;
  localparam logic [7:0] OFF_A_PLD = 8'h26;
  localparam logic [7:0] OFF_B_PLD = 8'h27;
  localparam logic [7:0] OFF_C_PLD = 8'h28;
  localparam logic [7:0] OFF_B_ALC = 8'h29;
  localparam logic [7:0] OFF_MODE = 8'h2a;
  localparam logic [7:0] DRV_RESET = 8'h00;
  localparam logic [7:0] MASK_A_SLEW = 8'h0f;
  localparam logic [7:0] MASK_A_OD = 8'hf0;
  localparam logic [7:0] MASK_C_OD = 8'h9c;
  localparam logic [7:0] MASK_D_SLEW = 8'h06;
  localparam logic [7:0] MASK_FULL = 8'hff;
  // Mode register fields, then third-port status pin positions
  localparam int MODE_PIO = 0;
  localparam int MODE_SIXPIN = 1;
  localparam int MODE_RDY = 2;
  localparam int PC_STAT = 3;
  localparam int PC_ERR = 4;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
    logic [7:0] d;
  } pdoc_ports_type;
endpackage : pdoc_pkg

// file: pdoc_port_cfg.sv
// The Wishbone register port was left to the implementer.
`timescale 1ns/100ps
module pdoc_port_cfg
  import pdoc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  input wire logic wb_sel_i,
  output logic [7:0] wb_dat_o,
  output logic wb_ack_o,
  // Logic array and repeater sources, same clock
  input pdoc_ports_type pld_oe_term,
  input pdoc_ports_type pld_out,
  input wire logic [7:0] mc_ab_out,
  input wire logic [7:0] mc_bc_out,
  input wire logic [7:0] cpu_addr_lo,
  input wire logic [7:0] cpu_addr_b,
  input wire logic [7:0] cpu_data_out,
  input wire logic pio_sel,
  input wire logic pio_rd_n,
  input wire logic prog_status_pin,
  input wire logic prog_error_pin,
  input wire logic flash_ready,
  input pdoc_ports_type port_dout,
  // Pin drivers
  output pdoc_ports_type pin_o,
  output pdoc_ports_type pin_oe_n,
  output pdoc_ports_type pin_fast_slew,
  output pdoc_ports_type pin_open_drain
);
  logic [7:0] drv_a_ff, drv_b_ff, drv_c_ff, drv_d_ff;
  logic [7:0] dir_a_ff, dir_b_ff, dir_c_ff, dir_d_ff;
  logic [7:0] adr_a_ff, adr_b_ff, pld_a_ff, pld_b_ff, pld_c_ff, alc_b_ff;
  logic [2:0] mode_ff;
  pdoc_ports_type oe_ff;
  logic [7:0] nxt_dat;

  wire wr_en = ce & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i & ~wb_ack_o;
  wire rd_en = ce & wb_cyc_i & wb_stb_i & ~wb_ack_o;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = wr_en && adr == off;
  endfunction : hit

  // Final output enable per pin
  wire pio_on = mode_ff[MODE_PIO];
  // Repeater drives only while addressed and not being read
  wire [7:0] oe_a = pio_on ? {8{pio_sel & pio_rd_n}} : // see RULE9
                    (dir_a_ff | adr_a_ff | (pld_a_ff & pld_oe_term.a));
  wire [7:0] oe_b = dir_b_ff | adr_b_ff | (pld_b_ff & pld_oe_term.b);
  wire sixpin = mode_ff[MODE_SIXPIN];
  logic [7:0] oe_c;
  always_comb begin
    oe_c = (dir_c_ff | (pld_c_ff & pld_oe_term.c)) & MASK_C_OD; // see RULE13
    if (mode_ff[MODE_RDY])
      oe_c[PC_STAT] = 1'b1; // see RULE16
    if (sixpin) begin
      oe_c[PC_STAT] = 1'b1; // see RULE14
      oe_c[PC_ERR] = 1'b1; // see RULE15
    end
  end
  wire [7:0] oe_d = (dir_d_ff | pld_oe_term.d) & MASK_D_SLEW;

  // Pin data selection
  wire [7:0] out_a = pio_on ? cpu_data_out : // see RULE11
    (adr_a_ff & cpu_addr_lo) |
    (~adr_a_ff & pld_a_ff & mc_ab_out) |
    (~adr_a_ff & ~pld_a_ff & port_dout.a);
  wire [7:0] mc_b = (alc_b_ff & mc_bc_out) | (~alc_b_ff & mc_ab_out);
  wire [7:0] out_b = (adr_b_ff & cpu_addr_b) | // see RULE12
    (~adr_b_ff & pld_b_ff & mc_b) |
    (~adr_b_ff & ~pld_b_ff & port_dout.b);
  logic [7:0] out_c;
  always_comb begin
    out_c = ((pld_c_ff & mc_bc_out) | (~pld_c_ff & port_dout.c)) & MASK_C_OD;
    if (mode_ff[MODE_RDY])
      out_c[PC_STAT] = flash_ready;
    if (sixpin) begin
      out_c[PC_STAT] = prog_status_pin;
      out_c[PC_ERR] = prog_error_pin;
    end
  end
  wire [7:0] out_d = port_dout.d & MASK_D_SLEW;

  // Register read mux; enable views show the output enable before open-drain release
  always_comb begin
    case (wb_adr_i)
      OFF_A_DRV: nxt_dat = drv_a_ff;
      OFF_B_DRV: nxt_dat = drv_b_ff;
      OFF_C_DRV: nxt_dat = drv_c_ff;
      OFF_D_DRV: nxt_dat = drv_d_ff;
      OFF_A_OEV: nxt_dat = oe_ff.a; // see RULE8
      OFF_B_OEV: nxt_dat = oe_ff.b;
      OFF_C_OEV: nxt_dat = oe_ff.c; // see RULE10
      OFF_D_OEV: nxt_dat = oe_ff.d;
      OFF_A_DIR: nxt_dat = dir_a_ff;
      OFF_B_DIR: nxt_dat = dir_b_ff;
      OFF_C_DIR: nxt_dat = dir_c_ff;
      OFF_D_DIR: nxt_dat = dir_d_ff;
      OFF_A_ADR: nxt_dat = adr_a_ff;
      OFF_B_ADR: nxt_dat = adr_b_ff;
      OFF_A_PLD: nxt_dat = pld_a_ff;
      OFF_B_PLD: nxt_dat = pld_b_ff;
      OFF_C_PLD: nxt_dat = pld_c_ff;
      OFF_B_ALC: nxt_dat = alc_b_ff;
      OFF_MODE: nxt_dat = {5'h00, mode_ff};
      default: nxt_dat = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 8'h00;
    end else if (ce) begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (rd_en)
        wb_dat_o <= nxt_dat;
    end
  end

  // Enable-out views have no write path, see RULE18
  always_ff @(posedge mclk) begin
    if (rst) begin
      drv_a_ff <= DRV_RESET; // see RULE3
      drv_b_ff <= DRV_RESET;
      drv_c_ff <= DRV_RESET;
      drv_d_ff <= DRV_RESET;
    end else begin
      if (hit(wb_adr_i, OFF_A_DRV)) drv_a_ff <= wb_dat_i; // see RULE4
      if (hit(wb_adr_i, OFF_B_DRV)) drv_b_ff <= wb_dat_i; // see RULE5
      if (hit(wb_adr_i, OFF_C_DRV))
        drv_c_ff <= wb_dat_i & MASK_C_OD; // see RULE6
      if (hit(wb_adr_i, OFF_D_DRV))
        drv_d_ff <= wb_dat_i & MASK_D_SLEW; // see RULE7
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      dir_a_ff <= 8'h00;
      dir_b_ff <= 8'h00;
      dir_c_ff <= 8'h00;
      dir_d_ff <= 8'h00;
      adr_a_ff <= 8'h00;
      adr_b_ff <= 8'h00;
      pld_a_ff <= 8'h00;
      pld_b_ff <= 8'h00;
      pld_c_ff <= 8'h00;
      alc_b_ff <= 8'h00;
      mode_ff <= 3'h0;
    end else begin
      if (hit(wb_adr_i, OFF_A_DIR)) dir_a_ff <= wb_dat_i;
      if (hit(wb_adr_i, OFF_B_DIR)) dir_b_ff <= wb_dat_i;
      if (hit(wb_adr_i, OFF_C_DIR)) dir_c_ff <= wb_dat_i & MASK_C_OD;
      if (hit(wb_adr_i, OFF_D_DIR)) dir_d_ff <= wb_dat_i & MASK_D_SLEW;
      if (hit(wb_adr_i, OFF_A_ADR)) adr_a_ff <= wb_dat_i;
      if (hit(wb_adr_i, OFF_B_ADR)) adr_b_ff <= wb_dat_i;
      if (hit(wb_adr_i, OFF_A_PLD)) pld_a_ff <= wb_dat_i;
      if (hit(wb_adr_i, OFF_B_PLD)) pld_b_ff <= wb_dat_i;
      if (hit(wb_adr_i, OFF_C_PLD)) pld_c_ff <= wb_dat_i & MASK_C_OD;
      if (hit(wb_adr_i, OFF_B_ALC)) alc_b_ff <= wb_dat_i;
      if (hit(wb_adr_i, OFF_MODE)) mode_ff <= wb_dat_i[2:0];
    end
  end

  // Pin stage; test-port positions never driven here
  always_ff @(posedge mclk) begin
    if (rst) begin
      oe_ff <= '0;
      pin_o <= '0;
      pin_oe_n <= '1;
      pin_fast_slew <= '0;
      pin_open_drain <= '0;
    end else if (ce) begin
      oe_ff <= '{a: oe_a, b: oe_b, c: oe_c, d: oe_d}; // see RULE17
      pin_o <= '{a: out_a, b: out_b, c: out_c, d: out_d};
      // Open drain: drive only low, release for high
      pin_oe_n <= '{a: ~(oe_a & ~(drv_a_ff & MASK_A_OD & out_a)), // see RULE1
                    b: ~(oe_b & ~(drv_b_ff & MASK_A_OD & out_b)),
                    c: ~(oe_c & ~(drv_c_ff & MASK_C_OD & out_c)),
                    d: ~oe_d};
      pin_fast_slew <= '{a: drv_a_ff & MASK_A_SLEW, // see RULE2
                         b: drv_b_ff & MASK_A_SLEW,
                         c: 8'h00,
                         d: drv_d_ff & MASK_D_SLEW};
      pin_open_drain <= '{a: drv_a_ff & MASK_A_OD, b: drv_b_ff & MASK_A_OD,
                          c: drv_c_ff & MASK_C_OD, d: 8'h00};
    end
  end
endmodule : pdoc_port_cfg

// file: pdoc_sva.sv
`timescale 1ns/100ps
module pdoc_sva
  import pdoc_pkg::*;
(
  // Bus side
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [7:0] wb_dat_o,
  // Pin side
  input pdoc_ports_type pin_oe_n,
  input pdoc_ports_type pin_fast_slew,
  input pdoc_ports_type pin_open_drain
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_take; wb_cyc_i && wb_stb_i && ce && !wb_ack_o; endsequence
  sequence s_answer; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_ack_take; s_take |=> s_answer; endproperty
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  property p_rst_vals; $fell(rst) |-> pin_oe_n == '1 && pin_fast_slew == '0
    && pin_open_drain == '0 && wb_dat_o == 8'h00; endproperty
  property p_a_split; pin_fast_slew.a[7:4] == 4'h0
    && pin_open_drain.a[3:0] == 4'h0; endproperty
  property p_b_split; pin_fast_slew.b[7:4] == 4'h0
    && pin_open_drain.b[3:0] == 4'h0; endproperty
  property p_c_mask; (pin_open_drain.c & ~MASK_C_OD) == 8'h00
    && pin_fast_slew.c == 8'h00; endproperty
  property p_d_mask; (pin_fast_slew.d & ~MASK_D_SLEW) == 8'h00
    && pin_open_drain.d == 8'h00; endproperty
  property p_scan_off; pin_oe_n.c[6:5] == 2'h3
    && pin_oe_n.c[1:0] == 2'h3; endproperty
  a_ack_take: assert property (p_ack_take)
    else $error("ack missing or too long");
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  a_rst_vals: assert property (p_rst_vals)
    else $error("bad reset state");
  a_a_split: assert property (p_a_split)
    else $error("first port drive split");
  a_b_split: assert property (p_b_split)
    else $error("second port drive split");
  a_c_mask: assert property (p_c_mask)
    else $error("third port drive mask");
  a_d_mask: assert property (p_d_mask)
    else $error("fourth port drive mask");
  a_scan_off: assert property (p_scan_off)
    else $error("scan pin driven");
endmodule : pdoc_sva

// file: pdoc_pin_loads.sv
`timescale 1ns/100ps
module pdoc_pin_loads
  import pdoc_pkg::*;
(
  // Driver side
  input pdoc_ports_type pin_o,
  input pdoc_ports_type pin_oe_n,
  // Pad levels
  output pdoc_ports_type pad
);
  // Weak pull-up on every pin, so a released pad reads high
  assign pad = pdoc_ports_type'((pin_o & ~pin_oe_n) | pin_oe_n);
endmodule : pdoc_pin_loads

// file: tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import pdoc_pkg::*;
  logic mclk, rst, ce, cyc, stb, we, sel, psel, prd_n, pst, per, rdy, ack;
  logic [7:0] adr, dat, rdat, cdo, dat_o;
  pdoc_ports_type dout, oet, pin_o, oe_n, fs, od, pad;
  int errors, tests_run, cyc_cnt;
  logic [7:0] offs [4] = '{OFF_A_DRV, OFF_B_DRV, OFF_C_DRV, OFF_D_DRV};
  logic [7:0] msk [4] = '{MASK_FULL, MASK_FULL, MASK_C_OD, MASK_D_SLEW};
  pdoc_port_cfg dut (.mclk(mclk), .rst(rst), .ce(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack), .pld_oe_term(oet),
    .pld_out('0), .mc_ab_out(8'h00), .mc_bc_out(8'h00),
    .cpu_addr_lo(8'h00), .cpu_addr_b(8'h00), .cpu_data_out(cdo),
    .pio_sel(psel), .pio_rd_n(prd_n), .prog_status_pin(pst),
    .prog_error_pin(per), .flash_ready(rdy), .port_dout(dout),
    .pin_o(pin_o), .pin_oe_n(oe_n), .pin_fast_slew(fs),
    .pin_open_drain(od));
  pdoc_pin_loads loads (.pin_o(pin_o), .pin_oe_n(oe_n), .pad(pad));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic tally_and_finish;
    if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  always @(posedge mclk) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    {cyc, stb, sel, we, adr, dat} <= {3'h7, w, a, d};
    do @(posedge mclk); while (ack !== 1'b1);
    rdat = dat_o;
    {cyc, stb} <= 2'h0;
    @(posedge mclk);
  endtask : wb
  task automatic chk(input logic [7:0] s, input logic [7:0] e, input string n);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Register write lands, then the pin stage needs one more edge
  task automatic wset(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
    repeat (2) @(posedge mclk);
  endtask : wset
  initial begin
    {cyc, stb, we, sel, psel, prd_n, pst, per, rdy, rst, ce} = 11'h003;
    {adr, dat, cdo, dout, oet} = '0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, offs[i], 8'h00);
      chk(rdat, DRV_RESET, "drive reset");
      wb(1'b1, offs[i], 8'hff);
      wb(1'b0, offs[i], 8'h00);
      chk(rdat, msk[i], "drive readback");
    end
    dout.a <= 8'h5a;
    wset(OFF_A_DIR, 8'hff);
    chk(fs.a, MASK_A_SLEW, "slew a");
    chk(od.b, MASK_A_OD, "od b");
    chk(fs.d, MASK_D_SLEW, "slew d");
    chk(oe_n.a, 8'h50, "od release a");
    chk(pad.a, 8'h5a, "pad a");
    wset(OFF_A_DRV, 8'h00);
    chk(oe_n.a, 8'h00, "push pull a");
    wb(1'b1, OFF_A_OEV, 8'h00);
    wb(1'b0, OFF_A_OEV, 8'h00);
    chk(rdat, 8'hff, "view a");
    wset(OFF_C_DIR, 8'hff);
    wb(1'b0, OFF_C_OEV, 8'h00);
    chk(rdat, MASK_C_OD, "view c");
    wset(OFF_D_DIR, 8'hff);
    wb(1'b0, OFF_D_OEV, 8'h00);
    chk(rdat, MASK_D_SLEW, "view d");
    wb(1'b0, 8'h3f, 8'h00);
    chk(rdat, 8'h00, "unmapped");
    oet.b <= 8'h3c;
    wset(OFF_B_PLD, 8'hff);
    wb(1'b0, OFF_B_OEV, 8'h00);
    chk(rdat, 8'h3c, "array enable b");
    {psel, prd_n, cdo} <= {2'h3, 8'hc3};
    wset(OFF_A_DIR, 8'h00);
    wset(OFF_MODE, 8'h01);
    chk(pin_o.a, 8'hc3, "repeater data");
    wb(1'b0, OFF_A_OEV, 8'h00);
    chk(rdat, 8'hff, "repeater drive");
    prd_n <= 1'b0;
    repeat (2) @(posedge mclk);
    wb(1'b0, OFF_A_OEV, 8'h00);
    chk(rdat, 8'h00, "repeater read");
    {pst, rdy} <= 2'h3;
    wset(OFF_C_DIR, 8'h00);
    wset(OFF_MODE, 8'h06);
    chk({6'h00, pin_o.c[4:3]}, 8'h01, "status pair");
    chk({6'h00, oe_n.c[4:3]}, 8'h01, "pair enable");
    pst <= 1'b0;
    wset(OFF_MODE, 8'h04);
    chk({7'h00, pin_o.c[3]}, 8'h01, "ready pin");
    tally_and_finish();
  end
endmodule : tb_top
bind pdoc_port_cfg pdoc_sva u_sva (.mclk(mclk), .rst(rst), .ce(ce),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o), .pin_oe_n(pin_oe_n), .pin_fast_slew(pin_fast_slew),
  .pin_open_drain(pin_open_drain));
